/* tb/holding_brake_sequencer_checker.sv */
// Port-level sequencing checks for the holding brake sequencer
`timescale 1ns/1ps
`default_nettype none
module brake_seq_checker (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Reset, active low
	input wire logic hreadyout, // Bus ready
	input wire logic hresp, // Bus response
	input wire logic servo_on_cmd, // Servo on level
	input wire logic alarm_in, // Alarm level
	input wire logic motor_running, // Motor moving
	input wire logic [2:0] other_func_out, // Other pin functions
	input wire logic motor_power_en, // Motor energised
	input wire logic [2:0] out_pair // Pin pair levels
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Pair bits owed to the brake alone
	wire logic [2:0] brk = out_pair & ~other_func_out;

	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not okay");
	AST_OFF_BRAKE: assert property ($fell(servo_on_cmd) && !motor_running |-> ##[1:6] brk == 3'h0)
		else $error("brake not applied at servo off");
	AST_ALM_BRAKE: assert property ($rose(alarm_in) && !motor_running |-> ##[1:6] brk == 3'h0)
		else $error("brake not applied at alarm");
	AST_ALM_POWER: assert property ($rose(alarm_in) |-> ##[1:6] !motor_power_en)
		else $error("power kept after alarm");
	AST_ALM_HOLD: assert property (alarm_in [*8] |-> !motor_power_en)
		else $error("power on during alarm");
	AST_IDLE_PINS: assert property ((!servo_on_cmd && !motor_running) [*8] |->
		out_pair == $past(other_func_out))
		else $error("pin pairs wrong while off");
	AST_PWR_CAUSE: assert property ($rose(motor_power_en) |-> $past(servo_on_cmd, 3))
		else $error("power without servo on");
	AST_REL_CAUSE: assert property ($rose(|brk) |-> $past(servo_on_cmd, 3))
		else $error("brake released without servo on");
	AST_RUN_STOP: assert property ($fell(servo_on_cmd) && motor_running |-> ##[1:6] !motor_power_en)
		else $error("power kept on running stop");
	AST_RUN_HOLD: assert property ($fell(servo_on_cmd) && motor_running && (|brk) |-> ##6 (|brk))
		else $error("brake applied while motor still fast");
	// Main scenarios reached
	cover property ($rose(motor_power_en));
	cover property ($rose(alarm_in));
	cover property ($fell(servo_on_cmd) && motor_running);
endmodule // brake_seq_checker
bind holding_brake_sequencer brake_seq_checker u_brake_seq_checker (.core_clk, .rstn,
	.hreadyout, .hresp, .servo_on_cmd, .alarm_in, .motor_running, .other_func_out,
	.motor_power_en, .out_pair);
`default_nettype wire

/* tb/holding_brake_sequencer_tb.sv */
// Self-checking bench for the holding brake sequencer
`timescale 1ns/1ps
`default_nettype none
module holding_brake_sequencer_tb;
	logic core_clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic servo_on_cmd = 1'h0, alarm_in = 1'h0, spin = 1'h0, hold = 1'h0, motor_running;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0, other_func_out = 3'h2, out_pair;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [6:0] motor_speed_rpm;
	wire logic hready, hreadyout, hresp, motor_power_en;
	logic [31:0] ra [6] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h20};
	logic [31:0] re [6] = '{32'h0, 32'h0, 32'h64, 32'h32, 32'hfff, 32'h0};
	int failures = 0, total_checks = 0;
	assign hready = hreadyout;
	always #2.5 core_clk = ~core_clk;
	holding_brake_sequencer #(.TICK_CYCLES(20)) u_holding_brake_sequencer (.core_clk, .rstn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .servo_on_cmd, .alarm_in, .motor_running, .motor_speed_rpm,
		.other_func_out, .motor_power_en, .out_pair);
	motor_brake_model #(.REF_WAIT(1100)) u_motor_brake_model (.core_clk,
		.power_on(motor_power_en), .brake_rel(out_pair[0]), .spin_req(spin),
		.hold_spd(hold), .motor_running, .motor_speed_rpm);
	// Verdict and end of run
	task automatic complete_run();
		if (failures == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for hready at rising edges; read data is taken at that same edge
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			d = hrdata;
			n++;
		end while (hready !== 1'h1 && n < 40);
		if (hready !== 1'h1) begin
			failures++;
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		wait_rdy(rd);
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(rd);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic son(input logic v);
		@(posedge core_clk);
		servo_on_cmd <= v;
	endtask
	// Counts cycles until power and pairs match, then checks the count window
	task automatic settle(input logic [3:0] exp, input int lo, input int hi);
		int n;
		n = 0;
		while ({motor_power_en, out_pair} !== exp && n <= hi) begin
			@(negedge core_clk);
			n++;
		end
		chk(n >= lo && n <= hi, 1'h1);
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'h1;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			rdc(ra[i], re[i]);
		end
		son(1'h1);
		settle(4'ha, 2, 12);
		son(1'h0);
		settle(4'h2, 2, 12);
		bus(1'h1, 32'h10, 32'h4f4);
		bus(1'h1, 32'h0, 32'h3);
		son(1'h1);
		settle(4'h7, 2, 12);
		settle(4'hf, 35, 70);
		bus(1'h1, 32'h4, 32'h2);
		son(1'h0);
		settle(4'ha, 2, 12);
		settle(4'h2, 350, 410);
		bus(1'h1, 32'h0, 32'hffd);
		son(1'h1);
		settle(4'ha, 2, 12);
		settle(4'hf, 35, 70);
		@(posedge core_clk);
		alarm_in <= 1'h1;
		settle(4'h2, 2, 12);
		repeat (8) @(posedge core_clk);
		son(1'h0);
		alarm_in <= 1'h0;
		bus(1'h1, 32'h0, 32'h0);
		bus(1'h1, 32'h8, 32'h50);
		bus(1'h1, 32'hc, 32'ha);
		spin <= 1'h1;
		son(1'h1);
		repeat (1200) @(posedge core_clk);
		son(1'h0);
		settle(4'h7, 2, 12);
		rdc(32'h14, 32'h204);
		settle(4'h2, 30, 50);
		rdc(32'h14, 32'h10);
		hold <= 1'h1;
		son(1'h1);
		repeat (1200) @(posedge core_clk);
		son(1'h0);
		repeat (1850) @(posedge core_clk);
		rdc(32'h14, 32'h204);
		repeat (200) @(posedge core_clk);
		rdc(32'h14, 32'h10);
		complete_run();
	end
endmodule // holding_brake_sequencer_tb
`default_nettype wire

/* tb/motor_brake_model.sv */
// Motor, brake and host reference timing model
`timescale 1ns/1ps
`default_nettype none
module motor_brake_model #(
	parameter integer REF_WAIT = 1100
) (
	input wire logic core_clk, // Clock
	input wire logic power_on, // Motor energised
	input wire logic brake_rel, // Brake release level
	input wire logic spin_req, // Host wants motion
	input wire logic hold_spd, // Load keeps motor turning
	output var logic motor_running, // Motor moving
	output var logic [6:0] motor_speed_rpm // Speed
);
	int rel_cnt = 0;
	initial motor_speed_rpm = 7'h00;
	// References only after the release wait; coasts down when not referenced unless hold_spd is set
	always @(posedge core_clk) begin
		rel_cnt <= brake_rel ? rel_cnt + 1 : 0;
		if (power_on && spin_req && rel_cnt >= REF_WAIT) begin
			motor_speed_rpm <= 7'h78;
		end else if (!hold_spd && motor_speed_rpm != 7'h00) begin
			motor_speed_rpm <= motor_speed_rpm - 7'h01;
		end
	end
	assign motor_running = motor_speed_rpm != 7'h00;
endmodule // motor_brake_model
`default_nettype wire

/* verilog/brake_seq_defs.vh */
// Constants for the holding brake sequencer
// What this block does
// - Brake release output drops on servo-off or alarm; high releases the brake.
// - Release output unassigned after reset; driven only on pairs selecting brake code.
// - Stopped motor: brake applies at servo-off, power held for off-wait (10 ms steps).
// - Positive on-wait: release brake first, energise motor after that many ms.
// - Negative on-wait: energise at once, release brake after its magnitude in ms.
// - Alarm removes motor power immediately, ignoring the off-wait.
// - Running motor stopping: brake applies once speed falls below threshold.
// - Running motor stopping: brake also applies after the brake timeout elapses.
// - Wait, threshold and timeout settings take effect immediately.
// - Several functions on one pin pair drive the OR of them all.
`ifndef BRAKE_SEQ_DEFS_VH
`define BRAKE_SEQ_DEFS_VH
`define CLK_FREQ_KHZ 200000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`CLK_FREQ_KHZ * `TICK_PERIOD_US) / 1000)
`define STEP_10MS 13'h000a
`define FUNC_BRAKE_CODE 4'h4
`define FUNC_UNASSIGNED 4'hf
`define ON_WAIT_RESET 12'h000
`define OFF_WAIT_RESET 9'h000
`define SPEED_THRESH_RESET 7'h64
`define BRAKE_TIMEOUT_RESET 7'h32
`define HOST_REF_WAIT_MS 50
`endif

/* verilog/holding_brake_sequencer.v */
// Holding brake sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "brake_seq_defs.vh"
module holding_brake_sequencer #(
	parameter integer TICK_CYCLES = `TICK_CYCLES
) (
	input wire core_clk, // 200 MHz control clock
	input wire rstn, // Async reset, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output wire hreadyout, // Slave ready, always high
	output wire hresp, // Always OKAY
	input wire servo_on_cmd, // Servo on request level, async
	input wire alarm_in, // Alarm level, async
	input wire motor_running, // Speed above run detect, async
	input wire [6:0] motor_speed_rpm, // Motor speed magnitude, same clock
	input wire [2:0] other_func_out, // Other functions already routed per pair
	output reg motor_power_en, // Motor energised
	output reg [2:0] out_pair // Output pin pair levels
);
	localparam [3:0] A_ON_WAIT = 4'h0;
	localparam [3:0] A_OFF_WAIT = 4'h4;
	localparam [3:0] A_SPEED = 4'h8;
	localparam [3:0] A_TIMEOUT = 4'hc;
	localparam [7:0] A_FUNC_SEL = 8'h10;
	localparam [7:0] A_STATUS = 8'h14;
	localparam [5:0] S_OFF = 6'h01;
	localparam [5:0] S_ON_BRK_FIRST = 6'h02;
	localparam [5:0] S_ON_PWR_FIRST = 6'h04;
	localparam [5:0] S_RUN = 6'h08;
	localparam [5:0] S_STOP_HOLD = 6'h10;
	localparam [5:0] S_STOP_RUN = 6'h20;

	// Settings registers
	reg [11:0] energise_wait_time_r; // Signed ms
	reg [8:0] deenergise_wait_time_r; // 10 ms steps
	reg [6:0] brake_speed_threshold_r;
	reg [6:0] brake_apply_timeout_r; // 10 ms steps
	reg [11:0] output_function_select_r; // Three 4-bit selectors
	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg brake_release_out;
	reg brake_nxt;
	reg power_nxt;
	reg [12:0] ms_cnt_r;
	reg ms_clr;
	reg [1:0] son_s_r;
	reg [1:0] alm_s_r;
	reg [1:0] run_s_r;
	reg son_d_r;
	reg alm_d_r;
	reg ap_valid_r;
	reg ap_write_r;
	reg [7:0] ap_addr_r;
	wire tick;
	wire son = son_s_r[1];
	wire alm = alm_s_r[1];
	wire running = run_s_r[1];
	wire on_ev = son & ~son_d_r & ~alm;
	wire off_ev = (~son & son_d_r) | (alm & ~alm_d_r);
	wire [11:0] on_mag = energise_wait_time_r[11] ? (~energise_wait_time_r + 12'h001) :
		energise_wait_time_r;
	wire [12:0] off_ms = {4'h0, deenergise_wait_time_r} * `STEP_10MS;
	wire [12:0] to_ms = {6'h00, brake_apply_timeout_r} * `STEP_10MS;

	ms_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick(tick)
	);

	// Input synchronisers
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			son_s_r <= 2'b00;
			alm_s_r <= 2'b00;
			run_s_r <= 2'b00;
			son_d_r <= 1'b0;
			alm_d_r <= 1'b0;
		end else begin
			son_s_r <= {son_s_r[0], servo_on_cmd};
			alm_s_r <= {alm_s_r[0], alarm_in};
			run_s_r <= {run_s_r[0], motor_running};
			son_d_r <= son;
			alm_d_r <= alm;
		end
	end

	// Millisecond counter, cleared on every sequence start
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			ms_cnt_r <= 13'h0000;
		else if (ms_clr)
			ms_cnt_r <= 13'h0000;
		else if (tick && ms_cnt_r != 13'h1fff)
			ms_cnt_r <= ms_cnt_r + 13'h0001;
	end

	// Sequencer; settings read live so edits act at once
	always @* begin
		state_nxt = state_r;
		brake_nxt = brake_release_out;
		power_nxt = motor_power_en;
		ms_clr = 1'b0;
		if (off_ev && state_r != S_OFF) begin
			ms_clr = 1'b1;
			if (running) begin
				// Brake stays released until the motor has slowed down or the brake timeout elapses
				power_nxt = 1'b0;
				state_nxt = S_STOP_RUN;
			end else begin
				brake_nxt = 1'b0;
				if (alm) begin
					power_nxt = 1'b0;
					state_nxt = S_OFF;
				end else begin
					state_nxt = S_STOP_HOLD;
				end
			end
		end else begin
			case (state_r)
				S_OFF: begin
					if (on_ev) begin
						ms_clr = 1'b1;
						if (energise_wait_time_r[11]) begin
							power_nxt = 1'b1;
							state_nxt = S_ON_PWR_FIRST;
						end else begin
							brake_nxt = 1'b1;
							state_nxt = S_ON_BRK_FIRST;
						end
					end
				end
				S_ON_BRK_FIRST: begin
					if (ms_cnt_r >= {1'b0, on_mag}) begin
						power_nxt = 1'b1;
						state_nxt = S_RUN;
					end
				end
				S_ON_PWR_FIRST: begin
					if (ms_cnt_r >= {1'b0, on_mag}) begin
						brake_nxt = 1'b1;
						state_nxt = S_RUN;
					end
				end
				S_RUN: state_nxt = S_RUN;
				S_STOP_HOLD: begin
					if (alm || ms_cnt_r >= off_ms) begin
						power_nxt = 1'b0;
						state_nxt = S_OFF;
					end
				end
				S_STOP_RUN: begin
					if (motor_speed_rpm < brake_speed_threshold_r || ms_cnt_r >= to_ms) begin
						brake_nxt = 1'b0;
						state_nxt = S_OFF;
					end
				end
				default: state_nxt = S_OFF;
			endcase
		end
	end

	// Sequencer state, brake release and motor power
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_OFF;
			brake_release_out <= 1'b0;
			motor_power_en <= 1'b0;
		end else begin
			state_r <= state_nxt;
			brake_release_out <= brake_nxt;
			motor_power_en <= power_nxt;
		end
	end

	// Pin pair mapping, ORed with other assigned functions
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			out_pair <= 3'b000;
		end else begin
			out_pair[0] <= other_func_out[0] | (brake_release_out &&
				output_function_select_r[3:0] == `FUNC_BRAKE_CODE);
			out_pair[1] <= other_func_out[1] | (brake_release_out &&
				output_function_select_r[7:4] == `FUNC_BRAKE_CODE);
			out_pair[2] <= other_func_out[2] | (brake_release_out &&
				output_function_select_r[11:8] == `FUNC_BRAKE_CODE);
		end
	end

	// AHB-Lite slave: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r <= 8'h00;
		end else if (hready) begin
			ap_valid_r <= hsel & htrans[1];
			ap_write_r <= hwrite;
			ap_addr_r <= haddr[7:0];
		end
	end

	// Register writes in data phase
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			energise_wait_time_r <= `ON_WAIT_RESET;
			deenergise_wait_time_r <= `OFF_WAIT_RESET;
			brake_speed_threshold_r <= `SPEED_THRESH_RESET;
			brake_apply_timeout_r <= `BRAKE_TIMEOUT_RESET;
			output_function_select_r <= {3{`FUNC_UNASSIGNED}};
		end else if (ap_valid_r && ap_write_r) begin
			case (ap_addr_r)
				{4'h0, A_ON_WAIT}: energise_wait_time_r <= hwdata[11:0];
				{4'h0, A_OFF_WAIT}: deenergise_wait_time_r <= hwdata[8:0];
				{4'h0, A_SPEED}: brake_speed_threshold_r <= hwdata[6:0];
				{4'h0, A_TIMEOUT}: brake_apply_timeout_r <= hwdata[6:0];
				A_FUNC_SEL: output_function_select_r <= hwdata[11:0];
				default: output_function_select_r <= output_function_select_r;
			endcase
		end
	end

	// Read mux; unmapped reads zero
	always @* begin
		hrdata = 32'h00000000;
		case (ap_addr_r)
			{4'h0, A_ON_WAIT}: hrdata = {{20{energise_wait_time_r[11]}}, energise_wait_time_r};
			{4'h0, A_OFF_WAIT}: hrdata = {23'h000000, deenergise_wait_time_r};
			{4'h0, A_SPEED}: hrdata = {25'h0000000, brake_speed_threshold_r};
			{4'h0, A_TIMEOUT}: hrdata = {25'h0000000, brake_apply_timeout_r};
			A_FUNC_SEL: hrdata = {20'h00000, output_function_select_r};
			A_STATUS: hrdata = {22'h000000, state_r, motor_power_en, brake_release_out,
				alm, son};
			default: hrdata = 32'h00000000;
		endcase
	end
endmodule // holding_brake_sequencer
`default_nettype wire

/* verilog/ms_tick_gen.v */
// Millisecond tick generator from the control clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
	parameter integer CYCLES = 200000
) (
	input wire core_clk, // Control clock
	input wire rstn, // Async reset, active low
	output reg tick // One-cycle pulse each period
);
	localparam integer W = $clog2(CYCLES);
	reg [W-1:0] cnt_r;

	// Free running divider
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= {W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_r == CYCLES[W-1:0] - 1'b1) begin
			cnt_r <= {W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // ms_tick_gen
`default_nettype wire
